// file: inc/lcdmcu_map.svh
`ifndef LCDMCU_MAP_SVH
`define LCDMCU_MAP_SVH
// ****************************************
// register offsets and fields
// ****************************************
`define LCDMCU_CTRL_OFS 8'h00
`define LCDMCU_STATUS_OFS 8'h04
`define LCDMCU_PADDR_OFS 8'h08
`define LCDMCU_PDATA_OFS 8'h0C
`define LCDMCU_MADDR_OFS 8'h10
`define LCDMCU_MDATA_OFS 8'h14
`define LCDMCU_CTRL_RUN_BIT 0
`define LCDMCU_RESP_OKAY 2'h0
`define LCDMCU_RESP_SLVERR 2'h2
// ****************************************
// start addresses
// ****************************************
`define LCDMCU_CLR_PU 2'h3
`define LCDMCU_CLR_PM 4'h7
`define LCDMCU_WAKE_PU 2'h1
`define LCDMCU_WAKE_PM 4'h0
`define LCDMCU_START_PL 6'h00
// ****************************************
// opcodes without printed codes
// ****************************************
`define LCDMCU_OP_HALT 8'h5D
`define LCDMCU_OP2_FAST 8'h36
`define LCDMCU_OP2_SLOW 8'h37
`define LCDMCU_DISP_FILE_A 3'h6
`define LCDMCU_DISP_FILE_B 3'h7
// ****************************************
// timing
// ****************************************
`define LCDMCU_MCLK_HZ 10000000
`define LCDMCU_XTAL_HZ 32768
`define LCDMCU_XTAL_DIV (`LCDMCU_MCLK_HZ / `LCDMCU_XTAL_HZ)
`define LCDMCU_DIV_STAGES 15
`define LCDMCU_CLR_WAIT_MS 500
`define LCDMCU_CLR_WAIT_XT (`LCDMCU_CLR_WAIT_MS * `LCDMCU_XTAL_HZ / 1000)
`define LCDMCU_NOTE_LONG_US 125000
`define LCDMCU_NOTE_SHORT_US 62500
`define LCDMCU_NOTE_LONG_XT (`LCDMCU_NOTE_LONG_US / 125 * `LCDMCU_XTAL_HZ / 8000)
`define LCDMCU_NOTE_SHORT_XT (`LCDMCU_NOTE_SHORT_US / 125 * `LCDMCU_XTAL_HZ / 8000)
`endif

// file: inc/lcdmcu_pkg.sv
package lcdmcu_pkg;
  typedef enum logic [1:0] {MODE_CLEAR, MODE_WAIT, MODE_RUN, MODE_HALT} lcdmcu_mode_type;
  typedef struct packed {
    lcdmcu_mode_type mode;
    logic [8:0] xtal_cnt;
    logic [1:0] sys_cnt;
    logic [14:0] div;
    logic [14:0] clr_cnt;
    logic fast;
    logic [3:0] acc;
    logic carry;
    logic [2:0] bm;
    logic [3:0] bl;
    logic [1:0] pu, su, ru;
    logic [3:0] pm, sm, rm;
    logic [5:0] pl, sl, rl;
    logic [7:0] wsh, wout;
    logic gamma, skip, pend, pend_skip, lax_prev;
    logic [7:0] pend_op;
    logic bp, bleeder_cut, blank;
    logic [3:0] lreg, xreg, yreg;
    logic tune_run, tune_done;
    logic [7:0] mel_ptr;
    logic [4:0] mel_half;
    logic [1:0] mel_phase;
    logic [12:0] mel_len;
    logic mel_out;
    logic [1:0] com_phase;
    logic frame_pol;
    logic [127:0][3:0] ram;
    logic [3:0] k1, k2, k3, key_f;
    logic [2:0] a1, a2, a3;
    logic clr_f, beta_f, ba_f;
    logic [31:0] seg_a, seg_b;
    logic [7:0] com;
    logic [1:0] bs1, bs2;
    logic ctrl_run;
    logic [11:0] prog_addr;
    logic [7:0] mel_addr;
    logic aw_got, w_got;
    logic [7:0] aw_addr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
  } lcdmcu_state_type;
endpackage

// file: hdl/lcdmcu_core.sv
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lcdmcu_map.svh"
module lcdmcu_core #(
  parameter int XTAL_DIV = `LCDMCU_XTAL_DIV,
  parameter int CLR_WAIT = `LCDMCU_CLR_WAIT_XT,
  parameter int SEC_BIT = `LCDMCU_DIV_STAGES - 1,
  parameter int NOTE_LONG = `LCDMCU_NOTE_LONG_XT,
  parameter int NOTE_SHORT = `LCDMCU_NOTE_SHORT_XT,
  parameter int COM_BIT = 6
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] key_in,
  input wire logic auto_clear,
  input wire logic beta_in,
  input wire logic ba_in,
  output logic [7:0] strobe_out,
  output logic [31:0] seg_a_lvl,
  output logic [31:0] seg_b_lvl,
  output logic [7:0] com_lvl,
  output logic [1:0] flash_segment_out,
  output logic [1:0] x_segment_out,
  output logic melody_out,
  output logic halted
);
  import lcdmcu_pkg::*;

  lcdmcu_state_type s_r, s_nxt;
  logic [7:0] prog_mem [0:4095];
  logic [5:0] mel_mem [0:255];
  logic prog_we, mel_we;

  // ****************************************
  // helper functions
  // ****************************************
  function automatic logic [5:0] pl_step(input logic [5:0] p);
    return {p[4:0], ~(p[5] ^ p[4])};
  endfunction

  function automatic logic is_two(input logic [7:0] op);
    return (op == 8'h5F) || (op == 8'h60) || (op == 8'h61) || (op[7:2] == 6'h1A) || (op[7:4] == 4'h7);
  endfunction

  function automatic logic reg_ok(input logic [7:0] a);
    return (a == `LCDMCU_CTRL_OFS) || (a == `LCDMCU_STATUS_OFS) || (a == `LCDMCU_PADDR_OFS) ||
           (a == `LCDMCU_PDATA_OFS) || (a == `LCDMCU_MADDR_OFS) || (a == `LCDMCU_MDATA_OFS);
  endfunction

  // half-period counts in crystal cycles, four phases per code
  function automatic logic [3:0] half_cnt(input logic [3:0] code, input logic [1:0] ph);
    logic [15:0] t;
    case (code)
      4'h2: t = 16'h7888;
      4'h3: t = 16'h8889;
      4'h4: t = 16'h8999;
      4'h5: t = 16'h999A;
      4'h6: t = 16'h9AAA;
      4'h7: t = 16'hABAB;
      4'h8: t = 16'hBBBB;
      4'h9: t = 16'hBCCC;
      4'hA: t = 16'hCDCD;
      4'hB: t = 16'hDDDE;
      4'hC: t = 16'hEEEE;
      4'hD: t = 16'hEFFF;
      default: t = 16'h0000;
    endcase
    return t[4'(12 - 4 * ph) +: 4];
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic xtal_tick, sys_tick, sec_rise, com_tick, on;
    logic [7:0] op, b;
    logic [6:0] ma;
    logic [3:0] mv, hc;
    logic [4:0] sum, hl;
    logic [5:0] pl_adv, ent;
    logic [12:0] lim;
    logic lvl;
    xtal_tick = 1'b0;
    sys_tick = 1'b0;
    sec_rise = 1'b0;
    com_tick = 1'b0;
    on = 1'b0;
    op = 8'h00;
    b = 8'h00;
    ma = 7'h00;
    mv = 4'h0;
    hc = 4'h0;
    sum = 5'h00;
    hl = 5'h00;
    pl_adv = 6'h00;
    ent = 6'h00;
    lim = 13'h0000;
    lvl = 1'b0;
    s_nxt = s_r;
    prog_we = 1'b0;
    mel_we = 1'b0;

    // pin synchronisers: value changes once stages two and three agree
    s_nxt.k1 = key_in;
    s_nxt.k2 = s_r.k1;
    s_nxt.k3 = s_r.k2;
    if (s_r.k2 == s_r.k3) begin
      s_nxt.key_f = s_r.k3;
    end
    s_nxt.a1 = {auto_clear, beta_in, ba_in};
    s_nxt.a2 = s_r.a1;
    s_nxt.a3 = s_r.a2;
    if (s_r.a2[2] == s_r.a3[2]) s_nxt.clr_f = s_r.a3[2];
    if (s_r.a2[1] == s_r.a3[1]) s_nxt.beta_f = s_r.a3[1];
    if (s_r.a2[0] == s_r.a3[0]) s_nxt.ba_f = s_r.a3[0];

    // crystal rate, system clock and divider
    xtal_tick = (s_r.xtal_cnt == 9'(XTAL_DIV - 1));
    s_nxt.xtal_cnt = xtal_tick ? 9'h000 : s_r.xtal_cnt + 9'h001;
    sys_tick = xtal_tick && (s_r.fast ? s_r.sys_cnt[0] : (&s_r.sys_cnt));
    sec_rise = xtal_tick && !s_r.div[SEC_BIT] && (&s_r.div[SEC_BIT-1:0]);
    com_tick = xtal_tick && (&s_r.div[COM_BIT:0]);
    if (xtal_tick) begin
      s_nxt.sys_cnt = s_r.sys_cnt + 2'h1;
      s_nxt.div = s_r.div + 15'h0001;
    end

    // ****************************************
    // sequencing modes
    // ****************************************
    op = prog_mem[{s_r.pu, s_r.pm, s_r.pl}];
    b = op;
    ma = {s_r.bm, s_r.bl};
    mv = s_r.ram[ma];
    pl_adv = pl_step(s_r.pl);
    case (s_r.mode)
      MODE_CLEAR: begin
        s_nxt.pu = `LCDMCU_CLR_PU;
        s_nxt.pm = `LCDMCU_CLR_PM;
        s_nxt.pl = `LCDMCU_START_PL;
        s_nxt.fast = 1'b0;
        s_nxt.bp = 1'b1;
        s_nxt.bleeder_cut = 1'b0;
        s_nxt.tune_run = 1'b0;
        s_nxt.skip = 1'b0;
        s_nxt.pend = 1'b0;
        s_nxt.clr_cnt = 15'h0000;
        if (!s_r.clr_f && s_r.ctrl_run) s_nxt.mode = MODE_WAIT;
      end
      MODE_WAIT: begin
        if (s_r.clr_f || !s_r.ctrl_run) begin
          s_nxt.mode = MODE_CLEAR;
        end else if (xtal_tick) begin
          s_nxt.clr_cnt = s_r.clr_cnt + 15'h0001;
          if (s_r.clr_cnt == 15'(CLR_WAIT - 1)) s_nxt.mode = MODE_RUN;
        end
      end
      MODE_HALT: begin
        if (s_r.clr_f || !s_r.ctrl_run) begin
          s_nxt.mode = MODE_CLEAR;
        end else if (sec_rise || (|s_r.key_f)) begin
          s_nxt.mode = MODE_RUN;
          s_nxt.pu = `LCDMCU_WAKE_PU;
          s_nxt.pm = `LCDMCU_WAKE_PM;
          s_nxt.pl = `LCDMCU_START_PL;
        end
      end
      MODE_RUN: begin
        if (s_r.clr_f || !s_r.ctrl_run) begin
          s_nxt.mode = MODE_CLEAR;
        end else if (sys_tick) begin
          s_nxt.pl = pl_adv;
          s_nxt.skip = 1'b0;
          if (s_r.pend) begin
            s_nxt.pend = 1'b0;
            if (!s_r.pend_skip) begin
              case (s_r.pend_op)
                8'h5F: begin
                  s_nxt.bm = b[6:4];
                  s_nxt.bl = b[3:0];
                end
                8'h60: begin
                  case (b)
                    8'h30: s_nxt.tune_run = 1'b0;
                    8'h31: s_nxt.tune_run = 1'b1;
                    8'h32: begin
                      s_nxt.skip = s_r.tune_done;
                      s_nxt.tune_done = 1'b0;
                    end
                    8'h33: s_nxt.yreg = s_r.acc;
                    8'h34: s_nxt.bleeder_cut = s_r.carry;
                    8'h35: begin
                      s_nxt.bp = s_r.acc[0];
                      s_nxt.blank = 1'b1;
                    end
                    `LCDMCU_OP2_FAST: s_nxt.fast = 1'b1;
                    `LCDMCU_OP2_SLOW: s_nxt.fast = 1'b0;
                    default: s_nxt.skip = 1'b0;
                  endcase
                end
                8'h61: s_nxt.mel_ptr = b;
                8'h68, 8'h69, 8'h6A, 8'h6B: begin
                  {s_nxt.ru, s_nxt.rm, s_nxt.rl} = {s_r.su, s_r.sm, s_r.sl};
                  {s_nxt.su, s_nxt.sm, s_nxt.sl} = {s_r.pu, s_r.pm, pl_adv};
                  s_nxt.pm = {2'b00, s_r.pend_op[1:0]};
                  s_nxt.pu = b[7:6];
                  s_nxt.pl = b[5:0];
                end
                default: begin
                  s_nxt.pm = s_r.pend_op[3:0];
                  s_nxt.pu = b[7:6];
                  s_nxt.pl = b[5:0];
                end
              endcase
            end
          end else if (s_r.skip) begin
            s_nxt.pend = is_two(op);
            s_nxt.pend_skip = 1'b1;
          end else if (is_two(op)) begin
            s_nxt.pend = 1'b1;
            s_nxt.pend_skip = 1'b0;
            s_nxt.pend_op = op;
          end else begin
            s_nxt.lax_prev = (op[7:4] == 4'h2);
            case (op[7:4])
              4'h0: begin
                case (op[3:0])
                  4'h0: {s_nxt.carry, s_nxt.acc} = {s_r.acc[0], s_r.carry, s_r.acc[3:1]};
                  4'h2: s_nxt.skip = 1'b0;
                  4'h3: s_nxt.pl = {s_r.pl[5:4], s_r.acc};
                  4'h4, 4'h5, 4'h6, 4'h7: s_nxt.ram[ma][op[1:0]] = 1'b0;
                  4'h8: s_nxt.acc = s_r.acc + mv;
                  4'h9: begin
                    sum = {1'b0, s_r.acc} + {1'b0, mv} + {4'h0, s_r.carry};
                    s_nxt.acc = sum[3:0];
                    s_nxt.carry = sum[4];
                    s_nxt.skip = sum[4];
                  end
                  4'hA: s_nxt.acc = ~s_r.acc;
                  4'hB: {s_nxt.acc, s_nxt.bl} = {s_r.bl, s_r.acc};
                  default: s_nxt.ram[ma][op[1:0]] = 1'b1;
                endcase
              end
              4'h1: begin
                s_nxt.acc = mv;
                if (op[3:2] != 2'h2) s_nxt.ram[ma] = s_r.acc;
                s_nxt.bm = {s_r.bm[2], s_r.bm[1:0] ^ op[1:0]};
                if (op[3:2] == 2'h1) begin
                  s_nxt.bl = s_r.bl + 4'h1;
                  s_nxt.skip = (s_r.bl == 4'hF);
                end else if (op[3:2] == 2'h3) begin
                  s_nxt.bl = s_r.bl - 4'h1;
                  s_nxt.skip = (s_r.bl == 4'h0);
                end
              end
              4'h2: begin
                s_nxt.acc = op[3:0];
                s_nxt.skip = s_r.lax_prev;
              end
              4'h3: begin
                sum = {1'b0, s_r.acc} + {1'b0, op[3:0]};
                s_nxt.acc = sum[3:0];
                s_nxt.skip = sum[4];
              end
              4'h4: begin
                s_nxt.bl = {2'b00, op[3:2]};
                s_nxt.bm = {1'b0, op[1:0]};
              end
              4'h5: begin
                case (op[3:0])
                  4'h0: s_nxt.acc = s_r.key_f;
                  4'h1: s_nxt.skip = s_r.beta_f;
                  4'h2: s_nxt.skip = !s_r.carry;
                  4'h3: s_nxt.skip = (s_r.acc == mv);
                  4'h4, 4'h5, 4'h6, 4'h7: s_nxt.skip = mv[op[1:0]];
                  4'h8: begin
                    s_nxt.skip = !s_r.gamma;
                    s_nxt.gamma = 1'b0;
                  end
                  4'h9: s_nxt.lreg = s_r.acc;
                  4'hA: s_nxt.skip = (s_r.acc == 4'h0);
                  4'hB: s_nxt.skip = (s_r.acc == s_r.bl);
                  4'hC: s_nxt.xreg = s_r.acc;
                  4'hD: s_nxt.mode = MODE_HALT;
                  4'hE: s_nxt.skip = s_r.ba_f;
                  default: s_nxt.skip = 1'b0;
                endcase
              end
              4'h6: begin
                case (op[3:0])
                  4'h2: s_nxt.wsh = {s_r.wsh[6:0], 1'b0};
                  4'h3: s_nxt.wsh = {s_r.wsh[6:0], 1'b1};
                  4'h4: begin
                    s_nxt.bl = s_r.bl + 4'h1;
                    s_nxt.skip = (s_r.bl == 4'hF);
                  end
                  4'h6: s_nxt.carry = 1'b0;
                  4'h7: s_nxt.carry = 1'b1;
                  4'hC: begin
                    s_nxt.bl = s_r.bl - 4'h1;
                    s_nxt.skip = (s_r.bl == 4'h0);
                  end
                  4'hD: s_nxt.wout = s_r.wsh;
                  4'hE, 4'hF: begin
                    {s_nxt.pu, s_nxt.pm, s_nxt.pl} = {s_r.su, s_r.sm, s_r.sl};
                    {s_nxt.su, s_nxt.sm, s_nxt.sl} = {s_r.ru, s_r.rm, s_r.rl};
                    s_nxt.skip = op[0];
                  end
                  default: s_nxt.skip = 1'b0;
                endcase
              end
              4'h8, 4'h9, 4'hA, 4'hB: s_nxt.pl = op[5:0];
              default: s_nxt.skip = 1'b0;
            endcase
          end
        end
      end
      default: s_nxt.mode = MODE_CLEAR;
    endcase
    if (sec_rise) s_nxt.gamma = 1'b1;

    // ****************************************
    // melody sequencer
    // ****************************************
    ent = mel_mem[s_r.mel_ptr];
    if (!s_r.tune_run) begin
      s_nxt.mel_out = 1'b0;
      s_nxt.mel_len = 13'h0000;
      s_nxt.mel_half = 5'h00;
      s_nxt.mel_phase = 2'h0;
    end else if (xtal_tick) begin
      if (ent[3:0] == 4'h0) begin
        s_nxt.tune_run = 1'b0;
        s_nxt.tune_done = 1'b1;
        s_nxt.mel_out = 1'b0;
      end else begin
        hc = half_cnt(ent[3:0], s_r.mel_phase);
        hl = ent[4] ? {hc, 1'b0} : {1'b0, hc};
        if (hc == 4'h0) begin
          s_nxt.mel_out = 1'b0;
        end else if (s_r.mel_half >= hl - 5'h01) begin
          s_nxt.mel_half = 5'h00;
          s_nxt.mel_phase = s_r.mel_phase + 2'h1;
          s_nxt.mel_out = ~s_r.mel_out;
        end else begin
          s_nxt.mel_half = s_r.mel_half + 5'h01;
        end
        lim = ent[5] ? 13'(NOTE_SHORT - 1) : 13'(NOTE_LONG - 1);
        s_nxt.mel_len = s_r.mel_len + 13'h0001;
        if (s_r.mel_len == lim) begin
          s_nxt.mel_len = 13'h0000;
          s_nxt.mel_ptr = s_r.mel_ptr + 8'h01;
          s_nxt.mel_half = 5'h00;
          s_nxt.mel_phase = 2'h0;
        end
      end
    end

    // ****************************************
    // lcd drive levels, 1/3 bias in four steps
    // ****************************************
    if (com_tick) begin
      s_nxt.com_phase = s_r.com_phase + 2'h1;
      if (s_r.com_phase == 2'h3) begin
        s_nxt.frame_pol = ~s_r.frame_pol;
        s_nxt.blank = 1'b0;
      end
    end
    on = s_r.bp && !s_r.bleeder_cut && !s_r.blank;
    for (int i = 0; i < 4; i++) begin
      if (!on) s_nxt.com[2*i +: 2] = 2'h0;
      else if (s_r.com_phase == 2'(i)) s_nxt.com[2*i +: 2] = s_r.frame_pol ? 2'h3 : 2'h0;
      else s_nxt.com[2*i +: 2] = s_r.frame_pol ? 2'h1 : 2'h2;
    end
    for (int i = 0; i < 16; i++) begin
      lvl = s_r.ram[{`LCDMCU_DISP_FILE_A, 4'(i)}][s_r.com_phase];
      s_nxt.seg_a[2*i +: 2] = !on ? 2'h0 : (lvl ^ s_r.frame_pol) ? 2'h3 : (s_r.frame_pol ? 2'h2 : 2'h1);
      lvl = s_r.ram[{`LCDMCU_DISP_FILE_B, 4'(i)}][s_r.com_phase];
      s_nxt.seg_b[2*i +: 2] = !on ? 2'h0 : (lvl ^ s_r.frame_pol) ? 2'h3 : (s_r.frame_pol ? 2'h2 : 2'h1);
    end
    // flashing segments blink with the one-second divider stage
    lvl = s_r.lreg[s_r.com_phase] && !(s_r.yreg[s_r.com_phase] && s_r.div[SEC_BIT]);
    s_nxt.bs1 = !on ? 2'h0 : (lvl ^ s_r.frame_pol) ? 2'h3 : (s_r.frame_pol ? 2'h2 : 2'h1);
    lvl = s_r.xreg[s_r.com_phase];
    s_nxt.bs2 = !on ? 2'h0 : (lvl ^ s_r.frame_pol) ? 2'h3 : (s_r.frame_pol ? 2'h2 : 2'h1);

    // ****************************************
    // axi4-lite slave
    // ****************************************
    if (s_axi_awvalid && !s_r.aw_got && !s_r.bvalid) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got && !s_r.bvalid) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = reg_ok(s_r.aw_addr) ? `LCDMCU_RESP_OKAY : `LCDMCU_RESP_SLVERR;
      case (s_r.aw_addr)
        `LCDMCU_CTRL_OFS: if (s_r.wstrb[0]) s_nxt.ctrl_run = s_r.wdata[`LCDMCU_CTRL_RUN_BIT];
        `LCDMCU_PADDR_OFS: s_nxt.prog_addr = s_r.wdata[11:0];
        `LCDMCU_PDATA_OFS: begin
          prog_we = 1'b1;
          s_nxt.prog_addr = s_r.prog_addr + 12'h001;
        end
        `LCDMCU_MADDR_OFS: s_nxt.mel_addr = s_r.wdata[7:0];
        `LCDMCU_MDATA_OFS: begin
          mel_we = 1'b1;
          s_nxt.mel_addr = s_r.mel_addr + 8'h01;
        end
        default: s_nxt.bvalid = 1'b1;
      endcase
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (s_r.rvalid) begin
      if (s_axi_rready) s_nxt.rvalid = 1'b0;
    end else if (s_axi_arvalid) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = reg_ok(s_axi_araddr) ? `LCDMCU_RESP_OKAY : `LCDMCU_RESP_SLVERR;
      case (s_axi_araddr)
        `LCDMCU_CTRL_OFS: s_nxt.rdata = {31'h00000000, s_r.ctrl_run};
        `LCDMCU_STATUS_OFS: s_nxt.rdata = {2'h0, s_r.mode, s_r.fast, s_r.carry, s_r.gamma, s_r.tune_run,
                                           s_r.tune_done, s_r.bm, s_r.bl, s_r.pu, s_r.pm, s_r.pl, s_r.acc};
        `LCDMCU_PADDR_OFS: s_nxt.rdata = {20'h00000, s_r.prog_addr};
        `LCDMCU_MADDR_OFS: s_nxt.rdata = {24'h000000, s_r.mel_addr};
        default: s_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // program and melody stores, loaded by software
  always_ff @(posedge mclk) begin
    if (prog_we) begin
      prog_mem[s_r.prog_addr] <= s_r.wdata[7:0];
    end
    if (mel_we) begin
      mel_mem[s_r.mel_addr] <= s_r.wdata[5:0];
    end
  end

  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
  assign strobe_out = s_r.wout;
  assign seg_a_lvl = s_r.seg_a;
  assign seg_b_lvl = s_r.seg_b;
  assign com_lvl = s_r.com;
  assign flash_segment_out = s_r.bs1;
  assign x_segment_out = s_r.bs2;
  assign melody_out = s_r.mel_out;
  assign halted = (s_r.mode == MODE_HALT);
endmodule
`default_nettype wire

// file: dv/lcdmcu_core_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module lcdmcu_core_assertions (
  input wire logic mclk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp lost");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata lost");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken early");
  wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid) else $error("no read answer");
  rresp_code_a: assert property (s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2) else $error("bad rresp");
  bresp_code_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad bresp");
endmodule
`default_nettype wire

// file: dv/lcdmcu_panel.sv
`timescale 1ns/1ps
`default_nettype none
module lcdmcu_panel (
  input wire logic [7:0] strobe_out,
  input wire logic [31:0] press,
  input wire logic clr_req,
  output logic [3:0] key_in,
  output logic auto_clear
);
  // key matrix: a pressed key joins its strobe line to its key line
  always_comb begin
    key_in = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (strobe_out[i]) key_in = key_in | press[4*i+:4];
    end
  end
  assign auto_clear = clr_req;
endmodule
`default_nettype wire

// file: dv/lcdmcu_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcdmcu_core_tb;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, press = 32'h0, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic beta_in = 1'b0, ba_in = 1'b0, clr_req = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, auto_clear, melody_out, halted;
  logic [1:0] s_axi_bresp, s_axi_rresp, flash_segment_out, x_segment_out, r;
  logic [31:0] s_axi_rdata, seg_a_lvl, seg_b_lvl;
  logic [7:0] strobe_out, com_lvl;
  logic [3:0] key_in;
  int num_errors = 0, total_checks = 0;
  // rows: write flag, byte address, data or expected read data, expected response
  localparam logic [31:0] ROWS [18] = '{32'h1080DC00, 32'h10C00630, 32'h1080DC10, 32'h10C00620, 32'h1080DC30,
    32'h10C00630, 32'h1080DC70, 32'h10C006D0, 32'h1080DCF0, 32'h10C005D0, 32'h10804000, 32'h10C005D0,
    32'h11800002, 32'h01C00002, 32'h10400000, 32'h00000000, 32'h10000010, 32'h00000010};
  lcdmcu_core #(.XTAL_DIV(4), .CLR_WAIT(8), .SEC_BIT(5), .NOTE_LONG(16), .NOTE_SHORT(8), .COM_BIT(1)) dut (.*);
  lcdmcu_panel panel (.*);
  initial begin
    forever #50 mclk = ~mclk;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wait_halt(input logic v);
    int n;
    n = 0;
    while (halted !== v && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    check({31'h0, halted}, {31'h0, v});
  endtask
  initial begin
    #2000000;
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (ROWS[i]) begin
      if (ROWS[i][28]) begin
        axi_wr(ROWS[i][27:20], {16'h0, ROWS[i][19:4]}, r);
      end else begin
        axi_rd(ROWS[i][27:20], d, r);
        check(d, {16'h0, ROWS[i][19:4]});
      end
      check({30'h0, r}, {28'h0, ROWS[i][3:0]});
    end
    // a write with no byte enables leaves run set
    s_axi_wstrb <= 4'h0;
    axi_wr(8'h00, 32'h0, r);
    s_axi_wstrb <= 4'hF;
    axi_rd(8'h00, d, r);
    check(d, 32'h00000001);
    // program at 3-7 runs one, zero, one into the strobe shifter, latches and halts
    wait_halt(1'b1);
    check({24'h0, strobe_out}, 32'h00000005);
    check({31'h0, melody_out}, 32'h0);
    // blank display ram: every segment unlit, one common selected
    check(seg_b_lvl, seg_a_lvl);
    check({31'h0, seg_a_lvl[1] ^ seg_a_lvl[0]}, 32'h1);
    check(seg_a_lvl, {16{seg_a_lvl[1:0]}});
    check({30'h0, com_lvl[1:0] ^ com_lvl[3:2] ^ com_lvl[5:4] ^ com_lvl[7:6]}, 32'h2);
    check({30'h0, flash_segment_out}, {30'h0, seg_a_lvl[1:0]});
    check({30'h0, x_segment_out}, {30'h0, seg_a_lvl[1:0]});
    press <= 32'h00000001;
    wait_halt(1'b0);
    press <= 32'h0;
    wait_halt(1'b1);
    clr_req <= 1'b1;
    repeat (10) @(posedge mclk);
    check({31'h0, halted}, 32'h0);
    clr_req <= 1'b0;
    wait_halt(1'b1);
    complete_run();
  end
endmodule
bind lcdmcu_core lcdmcu_core_assertions chk (.*);
`default_nettype wire
